//--- saau_unit.sv
/*
 saau_unit: effective address and operand alignment for the load/store path.
 assumes the pipeline holds a request until req_ready, and the downstream
 accepts one access per cycle while acc_ready is high.
*/
// Summary of operation
// - 32-bit effective addresses, translated downstream
// - effective address for every access kind
// - operand address is its lowest byte
// - aligned when low bits zero per size
// - crossing integer halfword becomes two byte accesses
// - crossing integer word split in two
// - multiple/string: words until boundary or end
// - aux halfword at 0xF raises exception
// - aux word above 0xC raises exception
// - aux doubleword above 0x8 raises exception
// - aux quadword nonzero low nibble raises exception
// - unlisted kinds pass unsplit, no exception
// - aux demanded alignment violated raises exception
// - aux forced alignment zeros low bits
// - cache ops ignore bits 27:31
// - tlb ops ignore in-page offset bits
// - branch targets and fetches are word aligned
// - operand past top continues at zero
// - address arithmetic wraps modulo 2^32
// - byte order per page attribute
// - attribute 0 big, 1 little endian
module saau_unit (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire saau_pkg::saau_op_e req_op,
    input wire logic req_quad,
    input wire saau_pkg::saau_size_e req_size,
    input wire logic [31:0] req_base,
    input wire logic [31:0] req_offset,
    input wire logic [7:0] req_len,
    input wire logic req_page_le,
    input wire logic [31:0] req_page_mask,
    input wire logic aux_need_size_align,
    input wire logic aux_need_word_align,
    input wire logic aux_force_align,
    output logic acc_valid,
    input wire logic acc_ready,
    output logic [31:0] acc_addr,
    output logic [4:0] acc_bytes,
    output logic acc_le,
    output logic acc_last,
    output logic align_exc,
    output logic [31:0] effective_addr,
    output logic aligned
);
    import saau_pkg::*;

    logic rst_meta, rst_sync;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // combinational address path
    logic [31:0] ea_sum, ea_eff;
    logic [4:0] op_bytes;
    logic [3:0] low;
    logic is_aligned, aux_exc, word_ok;
    always_comb begin
        // wraps naturally: 32-bit sum drops the carry
        ea_sum = req_base + req_offset;
        op_bytes = SIZE_BYTE;
        if (req_quad) begin
            op_bytes = SIZE_QUAD;
        end else begin
            case (req_size)
                SAAU_BYTE: op_bytes = SIZE_BYTE;
                SAAU_HALF: op_bytes = SIZE_HALF;
                SAAU_WORD: op_bytes = SIZE_WORD;
                SAAU_DBL: op_bytes = SIZE_DBL;
                default: op_bytes = SIZE_BYTE;
            endcase
        end
        ea_eff = ea_sum;
        case (req_op)
            SAAU_OP_AUX: begin
                if (aux_force_align) begin
                    ea_eff = ea_sum & ~{27'h0, op_bytes - 5'h01};
                end
            end
            SAAU_OP_CACHE: ea_eff = {ea_sum[31:CACHE_IGNORE_BITS], 5'h00};
            SAAU_OP_TLB: ea_eff = ea_sum & ~req_page_mask;
            SAAU_OP_BRANCH: ea_eff = {ea_sum[31:2], 2'b00};
            // next sequential fetch: base is current address, step of four
            SAAU_OP_SEQ: ea_eff = {req_base[31:2], 2'b00} + INSN_STEP;
            default: ea_eff = ea_sum;
        endcase
        low = ea_eff[3:0];
        is_aligned = (({27'h0, op_bytes} - 32'h1) & {28'h0, low}) == 32'h0;
        word_ok = low[1:0] == 2'b00;
        aux_exc = 1'b0;
        if (req_op == SAAU_OP_AUX && !aux_force_align) begin
            if (req_quad) begin
                aux_exc = low != QW_ZERO;
            end else begin
                case (req_size)
                    SAAU_HALF: aux_exc = low == QW_LAST;
                    SAAU_WORD: aux_exc = low > WORD_LIMIT;
                    SAAU_DBL: aux_exc = low > DW_LIMIT;
                    default: aux_exc = 1'b0;
                endcase
            end
            if (aux_need_size_align && !is_aligned) begin
                aux_exc = 1'b1;
            end
            if (aux_need_word_align && !word_ok) begin
                aux_exc = 1'b1;
            end
        end
    end

    // sequencer for split and multiple accesses
    saau_state_e state, next_state;
    logic [31:0] cur_addr, next_cur_addr;
    logic [7:0] remain, next_remain;
    logic cur_le, next_cur_le;
    logic [31:0] next_acc_addr, next_ea_out;
    logic [4:0] next_acc_bytes, first_bytes, chunk;
    logic next_acc_valid, next_acc_last, next_acc_le, next_exc, next_aligned;
    logic take, busy;
    logic [4:0] to_bound;

    assign busy = state != SAAU_IDLE;
    // a held access blocks new work; data outputs are registered
    // frozen clock enable must refuse, or a request would be lost
    assign req_ready = clk_en && rst_sync && !busy && (!acc_valid || acc_ready);
    assign take = req_valid && req_ready;

    always_comb begin
        next_state = state;
        next_cur_addr = cur_addr;
        next_remain = remain;
        next_cur_le = cur_le;
        next_acc_addr = acc_addr;
        next_acc_bytes = acc_bytes;
        next_acc_valid = acc_valid && !acc_ready;
        next_acc_last = acc_last;
        next_acc_le = acc_le;
        next_exc = 1'b0;
        next_ea_out = effective_addr;
        next_aligned = aligned;
        to_bound = 5'h10 - {1'b0, cur_addr[3:0]};
        chunk = (remain < 8'h04) ? remain[4:0] : SIZE_WORD;
        if (to_bound < chunk) begin
            chunk = to_bound;
        end
        first_bytes = op_bytes;
        if (take) begin
            next_ea_out = ea_eff;
            next_aligned = is_aligned;
            next_acc_le = req_page_le; // 0 big, 1 little
            next_cur_le = req_page_le;
            if (aux_exc) begin
                next_exc = 1'b1; // no access issued
            end else if (req_op == SAAU_OP_MULT) begin
                next_cur_addr = ea_eff;
                next_remain = req_len;
                if (req_len != LEN_RESET) begin
                    next_state = SAAU_MULTI;
                end
            end else if (req_op == SAAU_OP_INT && req_size == SAAU_HALF && low == QW_LAST) begin
                first_bytes = SIZE_BYTE;
                next_state = SAAU_SPLIT2;
            end else if (req_op == SAAU_OP_INT && req_size == SAAU_WORD && low > WORD_LIMIT) begin
                first_bytes = 5'h10 - {1'b0, low};
                next_state = SAAU_SPLIT2;
            end
            if (!aux_exc && req_op != SAAU_OP_MULT) begin
                // unlisted kinds issue one access unchanged
                next_acc_valid = 1'b1;
                next_acc_addr = ea_eff;
                next_acc_bytes = first_bytes;
                next_acc_last = next_state == SAAU_IDLE;
                next_cur_addr = ea_eff + {27'h0, first_bytes}; // wraps past top
                next_remain = {3'h0, op_bytes - first_bytes};
            end
        end else if (busy && (!acc_valid || acc_ready)) begin
            case (state)
                SAAU_SPLIT2: begin
                    next_acc_valid = 1'b1;
                    next_acc_addr = cur_addr; // second part starts at zero past top
                    next_acc_bytes = remain[4:0];
                    next_acc_last = 1'b1;
                    next_state = SAAU_IDLE;
                end
                SAAU_MULTI: begin
                    next_acc_valid = 1'b1;
                    next_acc_addr = cur_addr;
                    next_acc_bytes = chunk;
                    next_acc_last = remain == {3'h0, chunk};
                    next_cur_addr = cur_addr + {27'h0, chunk};
                    next_remain = remain - {3'h0, chunk};
                    if (remain == {3'h0, chunk}) begin
                        next_state = SAAU_IDLE;
                    end
                end
                default: next_state = SAAU_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= SAAU_IDLE;
            cur_addr <= 32'h0000_0000;
            remain <= LEN_RESET;
            cur_le <= 1'b0;
            acc_addr <= 32'h0000_0000;
            acc_bytes <= 5'h00;
            acc_valid <= 1'b0;
            acc_last <= 1'b0;
            acc_le <= 1'b0;
            align_exc <= 1'b0;
            effective_addr <= 32'h0000_0000;
            aligned <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            cur_addr <= next_cur_addr;
            remain <= next_remain;
            cur_le <= next_cur_le;
            acc_addr <= next_acc_addr;
            acc_bytes <= next_acc_bytes;
            acc_valid <= next_acc_valid;
            acc_last <= next_acc_last;
            acc_le <= next_acc_le;
            align_exc <= next_exc;
            effective_addr <= next_ea_out;
            aligned <= next_aligned;
        end
    end
endmodule // saau_unit

//--- saau_pkg.sv
/*
 saau_pkg: constants and types for the storage address alignment unit.
 assumes big-bit-numbering addresses mapped so that bit 31 is the lsb (index 0 here).
*/
package saau_pkg;
    localparam int unsigned EA_W = 32;
    localparam int unsigned RA_W = 36;
    localparam logic [3:0] QW_LAST = 4'hF;
    localparam logic [3:0] WORD_LIMIT = 4'hC;
    localparam logic [3:0] DW_LIMIT = 4'h8;
    localparam logic [3:0] QW_ZERO = 4'h0;
    localparam int unsigned CACHE_IGNORE_BITS = 5;
    localparam logic [31:0] INSN_STEP = 32'h0000_0004;
    localparam logic [4:0] SIZE_BYTE = 5'h01;
    localparam logic [4:0] SIZE_HALF = 5'h02;
    localparam logic [4:0] SIZE_WORD = 5'h04;
    localparam logic [4:0] SIZE_DBL = 5'h08;
    localparam logic [4:0] SIZE_QUAD = 5'h10;
    localparam logic [7:0] LEN_RESET = 8'h00;

    typedef enum logic [1:0] {
        SAAU_BYTE = 2'b00,
        SAAU_HALF = 2'b01,
        SAAU_WORD = 2'b10,
        SAAU_DBL = 2'b11
    } saau_size_e;

    typedef enum logic [2:0] {
        SAAU_OP_INT = 3'b000,
        SAAU_OP_AUX = 3'b001,
        SAAU_OP_MULT = 3'b010,
        SAAU_OP_CACHE = 3'b011,
        SAAU_OP_TLB = 3'b100,
        SAAU_OP_BRANCH = 3'b101,
        SAAU_OP_SEQ = 3'b110,
        SAAU_OP_OTHER = 3'b111
    } saau_op_e;

    typedef enum logic [1:0] {
        SAAU_IDLE = 2'b00,
        SAAU_SPLIT2 = 2'b01,
        SAAU_MULTI = 2'b10
    } saau_state_e;
endpackage

//--- saau_acc_sink.sv
/* saau_acc_sink: downstream stage taking accesses from saau_unit.
 assumes delay is changed only between accesses. */
module saau_acc_sink (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic acc_valid,
    input wire logic [1:0] delay,
    output logic acc_ready
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    always_comb next_cnt = (acc_valid && !acc_ready) ? cnt + 2'h1 : 2'h0;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt <= 2'h0;
        else cnt <= next_cnt;
    end
    // never ready without an access, so a stray accept cannot hide
    assign acc_ready = acc_valid && cnt >= delay;
endmodule // saau_acc_sink

//--- saau_assertions.sv
/* saau_checker: timing relations at the saau_unit ports.
 assumes one clock and reset_n active low. */
module saau_checker
    import saau_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire saau_pkg::saau_op_e req_op,
    input wire saau_pkg::saau_size_e req_size,
    input wire logic [31:0] req_base,
    input wire logic [31:0] req_offset,
    input wire logic req_page_le,
    input wire logic aux_force_align,
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic [4:0] acc_bytes,
    input wire logic acc_le,
    input wire logic align_exc,
    input wire logic [31:0] effective_addr
);
    logic tk;
    logic ax;
    logic [31:0] ea;
    assign tk = clk_en && req_valid && req_ready;
    assign ea = req_base + req_offset;
    assign ax = tk && req_op == SAAU_OP_AUX && !aux_force_align;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    aux_half_a: assert property (ax && req_size == SAAU_HALF && ea[3:0] == QW_LAST |=> align_exc)
        else $error("aux half not refused");
    aux_word_a: assert property (ax && req_size == SAAU_WORD && ea[3:0] > WORD_LIMIT |=> align_exc)
        else $error("aux word not refused");
    aux_dbl_a: assert property (ax && req_size == SAAU_DBL && ea[3:0] > DW_LIMIT |=> align_exc)
        else $error("aux dbl not refused");
    exc_no_acc_a: assert property (align_exc |-> !acc_valid)
        else $error("access beside exception");
    int_half_a: assert property (tk && req_op == SAAU_OP_INT && req_size == SAAU_HALF
        && ea[3:0] == QW_LAST |=> acc_valid && acc_bytes == 5'h01)
        else $error("half not split");
    int_word_a: assert property (tk && req_op == SAAU_OP_INT && req_size == SAAU_WORD
        && ea[3:0] > WORD_LIMIT |=> acc_addr + 32'(acc_bytes) == ($past(ea) | 32'hF) + 32'h1)
        else $error("word first piece wrong");
    cache_mask_a: assert property (tk && req_op == SAAU_OP_CACHE
        |=> effective_addr == ($past(ea) & 32'hFFFF_FFE0))
        else $error("cache address not masked");
    branch_word_a: assert property (tk && req_op == SAAU_OP_BRANCH |=> effective_addr[1:0] == 2'h0)
        else $error("branch target unaligned");
    int_endian_a: assert property (tk && req_op == SAAU_OP_INT |=> !align_exc && acc_le == $past(req_page_le))
        else $error("endian or exception wrong");
    cover property (align_exc);
    cover property (tk && req_op == SAAU_OP_MULT);
    cover property (acc_valid && acc_bytes == 5'h01);
endmodule // saau_checker
bind saau_unit saau_checker saau_checker_inst (.clk, .reset_n, .clk_en, .req_valid, .req_ready,
    .req_op, .req_size, .req_base, .req_offset, .req_page_le, .aux_force_align, .acc_valid,
    .acc_addr, .acc_bytes, .acc_le, .align_exc, .effective_addr);

//--- testbench.sv
/* testbench: directed scenarios for saau_unit.
 assumes saau_acc_sink downstream and the checker bound in. */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import saau_pkg::*;
    logic clk = 1'h0, reset_n = 1'h0, req_valid = 1'h0, req_quad = 1'h0, req_page_le = 1'h0;
    logic aux_need_size_align = 1'h0, aux_need_word_align = 1'h0, aux_force_align = 1'h0;
    logic clk_en = 1'h1;
    logic req_ready, acc_valid, acc_ready, acc_le, acc_last, align_exc, aligned;
    saau_op_e req_op = SAAU_OP_INT;
    saau_size_e req_size = SAAU_BYTE;
    logic [31:0] req_base = 32'h0, req_offset = 32'h0, req_page_mask = 32'hFFF;
    logic [31:0] acc_addr, effective_addr;
    logic [7:0] req_len = 8'h0A;
    logic [4:0] acc_bytes;
    logic [1:0] delay = 2'h2;
    int failures = 0, comparisons = 0;
    saau_unit saau_unit_inst (.clk, .reset_n, .clk_en, .req_valid, .req_ready, .req_op,
        .req_quad, .req_size, .req_base, .req_offset, .req_len, .req_page_le, .req_page_mask,
        .aux_need_size_align, .aux_need_word_align, .aux_force_align, .acc_valid, .acc_ready,
        .acc_addr, .acc_bytes, .acc_le, .acc_last, .align_exc, .effective_addr, .aligned);
    saau_acc_sink saau_acc_sink_inst (.clk, .reset_n, .acc_valid, .delay, .acc_ready);
    initial forever #10 clk = ~clk;
    task automatic summarize();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // every wait is bounded; a hang ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        #1;
        n++;
        if (n > 40) begin
            failures++;
            summarize();
        end
    endtask
    task automatic issue(saau_op_e op, saau_size_e sz, logic [31:0] a);
        int n = 0;
        req_op = op;
        req_size = sz;
        req_base = a;
        req_valid = 1'h1;
        while (req_ready !== 1'h1) tick(n);
        tick(n);
        req_valid = 1'h0;
    endtask
    task automatic piece(logic [31:0] a, logic [4:0] b, logic l);
        int n = 0;
        while (acc_valid !== 1'h1) tick(n);
        chk("acc_addr", a, acc_addr);
        chk("acc_bytes", 32'(b), 32'(acc_bytes));
        chk("acc_last", 32'(l), 32'(acc_last));
        while (acc_ready !== 1'h1) tick(n);
        tick(n);
    endtask
    task automatic exc_chk();
        chk("align_exc", 32'h1, 32'(align_exc));
        chk("acc_valid", 32'h0, 32'(acc_valid));
    endtask
    task automatic t_int();
        issue(SAAU_OP_INT, SAAU_HALF, 32'h0000_100F);
        piece(32'h0000_100F, 5'h01, 1'h0);
        piece(32'h0000_1010, 5'h01, 1'h1);
        delay = 2'h0;
        issue(SAAU_OP_INT, SAAU_WORD, 32'h0000_200D);
        chk("aligned", 32'h0, 32'(aligned));
        piece(32'h0000_200D, 5'h03, 1'h0);
        piece(32'h0000_2010, 5'h01, 1'h1);
        req_page_le = 1'h1;
        issue(SAAU_OP_INT, SAAU_WORD, 32'h0000_300C);
        chk("aligned", 32'h1, 32'(aligned));
        chk("acc_le", 32'h1, 32'(acc_le));
        piece(32'h0000_300C, 5'h04, 1'h1);
        req_page_le = 1'h0;
    endtask
    task automatic t_wrap();
        issue(SAAU_OP_MULT, SAAU_WORD, 32'h0000_000C);
        piece(32'h0000_000C, 5'h04, 1'h0);
        piece(32'h0000_0010, 5'h04, 1'h0);
        piece(32'h0000_0014, 5'h02, 1'h1);
        req_len = 8'h04;
        issue(SAAU_OP_MULT, SAAU_WORD, 32'hFFFF_FFFE);
        piece(32'hFFFF_FFFE, 5'h02, 1'h0);
        piece(32'h0000_0000, 5'h02, 1'h1);
    endtask
    task automatic t_aux();
        saau_size_e sz [4] = '{SAAU_HALF, SAAU_WORD, SAAU_DBL, SAAU_DBL};
        logic [3:0] lo [4] = '{4'hF, 4'hD, 4'h9, 4'h1};
        for (int i = 0; i < 4; i++) begin
            req_quad = (i == 3);
            issue(SAAU_OP_AUX, sz[i], {28'h000_0040, lo[i]});
            exc_chk();
        end
        issue(SAAU_OP_AUX, SAAU_DBL, 32'h0000_0420);
        piece(32'h0000_0420, 5'h10, 1'h1);
        req_quad = 1'h0;
        aux_need_word_align = 1'h1;
        issue(SAAU_OP_AUX, SAAU_HALF, 32'h0000_0402);
        exc_chk();
        aux_need_word_align = 1'h0;
        aux_need_size_align = 1'h1;
        issue(SAAU_OP_AUX, SAAU_WORD, 32'h0000_0406);
        exc_chk();
        aux_force_align = 1'h1;
        issue(SAAU_OP_AUX, SAAU_DBL, 32'h0000_040F);
        piece(32'h0000_0408, 5'h08, 1'h1);
        aux_force_align = 1'h0;
        aux_need_size_align = 1'h0;
    endtask
    task automatic t_freeze();
        int n = 0;
        clk_en = 1'h0;
        req_op = SAAU_OP_INT;
        req_size = SAAU_WORD;
        req_base = 32'h0000_0500;
        req_valid = 1'h1;
        repeat (3) tick(n);
        chk("req_ready", 32'h0, 32'(req_ready));
        chk("acc_valid", 32'h0, 32'(acc_valid));
        clk_en = 1'h1;
        issue(SAAU_OP_INT, SAAU_WORD, 32'h0000_0500);
        piece(32'h0000_0500, 5'h04, 1'h1);
    endtask
    task automatic t_ops();
        saau_op_e op [5] = '{SAAU_OP_CACHE, SAAU_OP_TLB, SAAU_OP_BRANCH, SAAU_OP_SEQ, SAAU_OP_OTHER};
        logic [31:0] ad [5] = '{32'hFFFF_FFF3, 32'h1234_5678, 32'h107, 32'hFFFF_FFFC, 32'hF};
        logic [31:0] ex [5] = '{32'h20, 32'h1234_5000, 32'h144, 32'h0, 32'h4F};
        req_offset = 32'h40;
        for (int i = 0; i < 5; i++) begin
            issue(op[i], SAAU_WORD, ad[i]);
            chk("effective_addr", ex[i], effective_addr);
            chk("align_exc", 32'h0, 32'(align_exc));
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 reset_n = 1'h1;
        t_int();
        t_wrap();
        t_aux();
        t_freeze();
        t_ops();
        summarize();
    end
endmodule // testbench
